// [logic/tfm_monitor.sv]
`timescale 1ns/10ps
module tfm_monitor #(
  parameter int RETRY_UNIT = tfm_pkg::RETRY_UNIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input tfm_pkg::tfm_cmd_t cmd,
  input wire logic [15:0] temp_lin,
  input wire logic enable_pin,
  input wire logic bias_ok_pin,
  input wire logic write_protect_pin,
  input wire logic operation_on,
  input wire logic other_fault,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic output_on,
  output logic host_alert_line_n,
  output tfm_pkg::tfm_status_t status
);
  import tfm_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [15:0] ot_fault_limit;
  logic [15:0] overtemp_warning_threshold;
  logic [15:0] undertemp_warning_threshold;
  logic [15:0] undertemp_fault_threshold;
  logic [7:0] ot_action;
  logic [1:0] en_meta, bias_meta, wp_meta;
  logic conv_ok;
  logic en_sync, bias_sync, wp_sync;
  logic [15:0] lin_in [5];
  logic signed [FIX_W-1:0] fix_out [5];
  logic ot_fault_now, ot_warn_now, ut_warn_now, ut_fault_now, cool;
  logic clear_cmd, wr_ok, run_ok;
  tfm_status_t next_status;
  tfm_state_t state, next_state;
  logic [CNT_W-1:0] since_start;
  logic [CNT_W-1:0] delay_cyc;
  logic [1:0] act;
  logic [2:0] retry;

  // Pins from outside the clock domain pass two flops first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_meta <= 2'h0;
      bias_meta <= 2'h0;
      wp_meta <= 2'h0;
    end else begin
      en_meta <= {en_meta[0], enable_pin};
      bias_meta <= {bias_meta[0], bias_ok_pin};
      wp_meta <= {wp_meta[0], write_protect_pin};
    end
  end

  // Only the second flop of each pair is read
  assign en_sync = en_meta[1];
  assign bias_sync = bias_meta[1];
  assign wp_sync = wp_meta[1];

  // Command decode; clear is accepted even under write protect
  assign clear_cmd = cmd.wr && (cmd.code == CMD_CLEAR_FAULTS);
  assign wr_ok = cmd.wr && !wp_sync;

  // Threshold and action registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ot_fault_limit <= RST_OT_FAULT;
      overtemp_warning_threshold <= RST_OT_WARN;
      undertemp_warning_threshold <= RST_UT_WARN;
      undertemp_fault_threshold <= RST_UT_FAULT;
      ot_action <= RST_OT_ACTION;
    end else if (wr_ok) begin
      case (cmd.code)
        CMD_OT_FAULT_LIMIT: ot_fault_limit <= cmd.data;
        CMD_OT_WARN: overtemp_warning_threshold <= cmd.data;
        CMD_UT_WARN: undertemp_warning_threshold <= cmd.data;
        CMD_UT_FAULT: undertemp_fault_threshold <= cmd.data;
        CMD_OT_ACTION: ot_action <= cmd.data[7:0];
        default: ;
      endcase
    end
  end

  // Read port answers one cycle after the request; unknown codes read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0;
    end else begin
      rd_valid <= cmd.rd;
      case (cmd.code)
        CMD_OT_FAULT_LIMIT: rd_data <= ot_fault_limit;
        CMD_OT_WARN: rd_data <= overtemp_warning_threshold;
        CMD_UT_WARN: rd_data <= undertemp_warning_threshold;
        CMD_UT_FAULT: rd_data <= undertemp_fault_threshold;
        CMD_OT_ACTION: rd_data <= {8'h0, ot_action};
        CMD_STATUS_TEMP: rd_data <= {8'h0, status.ot_fault, status.ot_warn, status.ut_warn, status.ut_fault, 4'h0};
        CMD_STATUS_WORD: rd_data <= {13'h0, status.summary, 2'h0};
        default: rd_data <= 16'h0;
      endcase
    end
  end

  // Convert measurement and thresholds to one fixed-point scale
  assign lin_in[0] = temp_lin;
  assign lin_in[1] = ot_fault_limit;
  assign lin_in[2] = overtemp_warning_threshold;
  assign lin_in[3] = undertemp_warning_threshold;
  assign lin_in[4] = undertemp_fault_threshold;

  for (genvar i = 0; i < 5; i++) begin : g_conv
    tfm_lin_to_fixed #(.W(FIX_W), .FRAC(FIX_FRAC)) u_conv (
      .clk(clk),
      .nrst(nrst),
      .lin(lin_in[i]),
      .fixed(fix_out[i])
    );
  end

  // Converters hold zero until their first edge; all-zero words would fake an under fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_ok <= 1'b0;
    end else begin
      conv_ok <= 1'b1;
    end
  end

  // Threshold comparisons; the under fault trips on reaching its level
  assign ot_fault_now = conv_ok && (fix_out[0] > fix_out[1]);
  assign ot_warn_now = conv_ok && (fix_out[0] > fix_out[2]);
  assign ut_warn_now = conv_ok && (fix_out[0] < fix_out[3]);
  assign ut_fault_now = conv_ok && (fix_out[0] <= fix_out[4]);
  assign cool = fix_out[0] < fix_out[2];

  // Sticky status; a condition present during clear sets the bit again
  always_comb begin
    if (clear_cmd) begin
      next_status = '0;
    end else begin
      next_status = status;
    end
    next_status.ot_fault = next_status.ot_fault | ot_fault_now;
    next_status.ot_warn = next_status.ot_warn | ot_warn_now;
    next_status.ut_warn = next_status.ut_warn | ut_warn_now;
    next_status.ut_fault = next_status.ut_fault | ut_fault_now;
    next_status.summary = next_status.summary | ot_fault_now | ot_warn_now | ut_warn_now | ut_fault_now;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Alert line is low while any latched bit stands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_alert_line_n <= 1'b1;
    end else begin
      host_alert_line_n <= ~|next_status;
    end
  end

  // Response fields and retry spacing
  assign act = ot_action[ACT_HI:ACT_LO];
  assign retry = ot_action[RETRY_HI:RETRY_LO];
  assign delay_cyc = CNT_W'((CNT_W'(ot_action[DELAY_HI:DELAY_LO]) + CNT_W'(1)) * CNT_W'(RETRY_UNIT));
  assign run_ok = en_sync && operation_on && bias_sync && !other_fault;

  // Time since the last attempt start, saturating so a first fault is not delayed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_start <= '1;
    end else if (next_state == ST_RUN && state != ST_RUN) begin
      since_start <= CNT_W'(1); // Start cycle counts, so attempts land one period apart
    end else if (since_start != '1) begin
      since_start <= since_start + CNT_W'(1);
    end
  end

  // Fault response sequence
  always_comb begin
    next_state = state;
    if (!run_ok && state != ST_LATCH) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (run_ok && !ot_fault_now) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (ot_fault_now) begin
            case (act)
              ACT_RETRY: next_state = (retry == RETRY_CONT) ? ST_WAIT : ST_LATCH;
              ACT_HOLD: next_state = ST_HOLD;
              default: next_state = ST_LATCH;
            endcase
          end
        end
        ST_HOLD: begin
          if (cool) begin
            next_state = ST_RUN;
          end
        end
        ST_WAIT: begin
          if (cool && since_start >= delay_cyc) begin
            next_state = ST_RUN;
          end
        end
        ST_LATCH: begin
          if (clear_cmd) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Output enable follows the sequence from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_on <= 1'b0;
    end else begin
      output_on <= (next_state == ST_RUN);
    end
  end

  retry_off_a: assert property ((state == ST_RUN && ot_fault_now && act == ACT_RETRY) |=> !output_on)
    else $error("output stayed on after fault in retry mode");
  hold_resume_a: assert property ((state == ST_HOLD && run_ok && cool) |=> output_on)
    else $error("hold mode did not resume when cool");
  no_retry_a: assert property ((state == ST_LATCH && !clear_cmd) |=> (!output_on && state == ST_LATCH))
    else $error("latched shutdown restarted without clear");
  cont_retry_a: assert property ((state == ST_WAIT && run_ok && cool && since_start >= delay_cyc) |=> output_on)
    else $error("continuous retry did not restart");
  retry_cool_a: assert property ((state == ST_WAIT && next_state == ST_RUN) |-> cool)
    else $error("restart while still hot");
  retry_gap_a: assert property ((state == ST_WAIT && next_state == ST_RUN) |-> since_start >= delay_cyc)
    else $error("restart attempts too close together");
  fault_alert_a: assert property (ot_fault_now |=> (!host_alert_line_n && status.ot_fault))
    else $error("fault did not pull alert or set bit");
  fault_sticky_a: assert property ((status.ot_fault && !clear_cmd) |=> status.ot_fault)
    else $error("fault bit dropped without clear");
  ot_warn_set_a: assert property (ot_warn_now |=> (status.ot_warn && status.summary && !host_alert_line_n))
    else $error("over warning not flagged");
  ut_warn_set_a: assert property (ut_warn_now |=> (status.ut_warn && status.summary && !host_alert_line_n))
    else $error("under warning not flagged");
  ut_fault_set_a: assert property (ut_fault_now |=> status.ut_fault)
    else $error("under fault not flagged");
  wp_block_a: assert property ((cmd.wr && wp_sync && cmd.code == CMD_OT_WARN) |=> $stable(overtemp_warning_threshold))
    else $error("write passed while protected");
  reserved_act_a: assert property ((state == ST_RUN && run_ok && ot_fault_now && !act[1]) |=> state == ST_LATCH)
    else $error("reserved action code acted on");
endmodule

// [shared/tfm_pkg.sv]
package tfm_pkg;

  // Command codes of the management bus port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_UT_WARN = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT = 8'h53;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;

  // Values after reset
  localparam logic [15:0] RST_OT_FAULT = 16'hebe8;
  localparam logic [15:0] RST_OT_WARN = 16'heb70;
  localparam logic [15:0] RST_UT_WARN = 16'hdc40;
  localparam logic [15:0] RST_UT_FAULT = 16'he530;
  localparam logic [7:0] RST_OT_ACTION = 8'hbf;

  // Field positions of the fault action byte
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  // Field positions of a linear threshold word
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MANT_HI = 10;

  // Response codes
  localparam logic [1:0] ACT_RETRY = 2'h2;
  localparam logic [1:0] ACT_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_CONT = 3'h7;

  // Status bit positions
  localparam int ST_OT_FAULT_BIT = 7;
  localparam int ST_OT_WARN_BIT = 6;
  localparam int ST_UT_WARN_BIT = 5;
  localparam int ST_UT_FAULT_BIT = 4;
  localparam int SW_TEMP_BIT = 2;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RETRY_UNIT_NS = 35_000_000;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int FIX_W = 40;
  localparam int FIX_FRAC = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } tfm_cmd_t;

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic ut_warn;
    logic ut_fault;
    logic summary;
  } tfm_status_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_WAIT, ST_LATCH} tfm_state_t;

endpackage

// [logic/tfm_lin_to_fixed.sv]
`timescale 1ns/10ps
module tfm_lin_to_fixed #(
  parameter int W = 40,
  parameter int FRAC = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] lin,
  output logic signed [W-1:0] fixed
);
  import tfm_pkg::*;

  logic signed [W-1:0] base;
  logic signed [W-1:0] shifted;
  logic [4:0] neg_exp;

  // Mantissa times two to the exponent, as fixed point with FRAC fraction bits
  always_comb begin
    base = signed'({{(W-11){lin[MANT_HI]}}, lin[MANT_HI:0]}) <<< FRAC;
    neg_exp = 5'(~lin[EXP_HI:EXP_LO] + 5'h1);
    if (lin[EXP_HI]) begin
      shifted = base >>> neg_exp; // Truncates toward minus infinity
    end else begin
      shifted = base <<< lin[EXP_HI:EXP_LO];
    end
  end

  // Registered so the comparators see a clean word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fixed <= '0;
    end else begin
      fixed <= shifted;
    end
  end
endmodule

// [tb/tfm_host.sv]
`timescale 1ns/10ps
module tfm_host (
  input wire logic clk,
  output tfm_pkg::tfm_cmd_t cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  import tfm_pkg::*;
  initial cmd = '0;
  // One request per call; on release both strobes drop and code and data show the inverse so stale data never looks valid
  task automatic issue(input logic w, input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd <= '{w, ~w, code, data};
    @(posedge clk);
    cmd <= '{1'b0, 1'b0, ~code, ~data};
  endtask
  // Answer stands only in the cycle after the taking edge, so look just after that edge
  task automatic read(input logic [7:0] code, output logic [15:0] data);
    issue(1'b0, code, 16'h0000);
    #1;
    data = rd_valid ? rd_data : 16'hxxxx;
  endtask
  // Latched bits drop only through this command
  task automatic clear();
    issue(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import tfm_pkg::*;
  localparam int UNIT = 8;
  localparam logic [7:0] CODES [6] = '{8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h60};
  localparam logic [15:0] RSTV [6] = '{16'hebe8, 16'h00bf, 16'heb70, 16'hdc40, 16'he530, 16'h0000};
  localparam logic [7:0] LATCH [5] = '{8'h80, 8'h3f, 8'h5f, 8'h9a, 8'hb0};
  localparam logic [3:0] OFFS [4] = '{4'b0110, 4'b1010, 4'b1100, 4'b1111};
  logic clk, nrst, enable_pin, bias_ok_pin, write_protect_pin, operation_on, other_fault;
  logic [15:0] temp_lin, rd_data, rv;
  logic rd_valid, output_on, host_alert_line_n;
  tfm_cmd_t cmd;
  tfm_status_t status;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'hc7ec;
  int cyc = 0;
  int w, d, c, t1;
  tfm_host host (.clk(clk), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));
  tfm_monitor #(.RETRY_UNIT(UNIT)) uut (.clk(clk), .nrst(nrst), .cmd(cmd), .temp_lin(temp_lin),
    .enable_pin(enable_pin), .bias_ok_pin(bias_ok_pin), .write_protect_pin(write_protect_pin),
    .operation_on(operation_on), .other_fault(other_fault), .rd_data(rd_data), .rd_valid(rd_valid),
    .output_on(output_on), .host_alert_line_n(host_alert_line_n), .status(status));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Whole degrees with a zero exponent keep expectations exact
  function automatic logic [15:0] deg(int t);
    return {5'h00, t[10:0]};
  endfunction
  function automatic logic [15:0] st(logic of, logic ow, logic uw, logic uf);
    return {11'h000, of, ow, uw, uf, of | ow | uw | uf};
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic temp(int t, int n);
    @(posedge clk);
    temp_lin <= deg(t);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic run(logic [3:0] m);
    @(posedge clk);
    {enable_pin, bias_ok_pin, operation_on, other_fault} <= m;
  endtask
  // Bounded wait for the power output to reach a level
  task automatic wait_out(logic v, int lim);
    c = 0;
    while (output_on !== v && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
    check(output_on, v, "output state");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well above the under two thousand cycles the tests need
  initial begin
    #(20000 * 50);
    n_mismatch++;
    final_report();
  end
  initial begin
    nrst = 1'b0;
    {enable_pin, bias_ok_pin, operation_on, other_fault} = 4'b1110;
    write_protect_pin = 1'b0;
    temp_lin = deg(25);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      host.read(CODES[i], rv);
      check(rv, RSTV[i], "reset value");
    end
    wait_out(1'b1, 10);
    check({15'h0, host_alert_line_n}, 16'h1, "alert idle");
    $display("test reset done");
    // Protected write is dropped, then a legal random threshold sticks
    // The pin needs two edges through its synchroniser before a write sees it
    @(posedge clk) write_protect_pin <= 1'b1;
    repeat (2) @(posedge clk);
    host.issue(1'b1, CMD_OT_WARN, deg(150));
    host.read(CMD_OT_WARN, rv);
    check(rv, 16'heb70, "protected write");
    @(posedge clk) write_protect_pin <= 1'b0;
    repeat (2) @(posedge clk);
    w = 60 + $unsigned($random(seed)) % 60;
    host.issue(1'b1, CMD_OT_WARN, deg(w));
    host.read(CMD_OT_WARN, rv);
    check(rv, deg(w), "threshold write");
    $display("test protect done");
    temp(w, 4);
    check({11'h0, status}, st(0, 0, 0, 0), "at warn limit");
    temp(w + 1, 4);
    check({11'h0, status}, st(0, 1, 0, 0), "over warn");
    check({14'h0, host_alert_line_n, output_on}, 16'h1, "warn alert");
    temp(25, 4);
    host.read(CMD_STATUS_TEMP, rv);
    check(rv, 16'h0040, "warn latched");
    host.read(CMD_STATUS_WORD, rv);
    check({15'h0, rv[2]}, 16'h1, "summary bit");
    host.clear();
    temp(25, 3);
    check({11'h0, status}, st(0, 0, 0, 0), "cleared");
    temp(-30, 4);
    check({11'h0, status}, st(0, 0, 0, 0), "at under limit");
    temp(-31, 4);
    check({11'h0, status}, st(0, 0, 1, 0), "under warn");
    temp(-45, 4);
    check({11'h0, status}, st(0, 0, 1, 1), "under fault");
    temp(25, 2);
    host.clear();
    temp(25, 3);
    check({14'h0, host_alert_line_n, status.ut_fault}, 16'h2, "under cleared");
    $display("test warnings done");
    // Retry spacing measured between attempt starts, delay 7 first
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 7 : $unsigned($random(seed)) % 8;
      host.issue(1'b1, CMD_OT_ACTION, {8'h00, 5'b10111, d[2:0]});
      temp(130, 4);
      check({11'h0, status}, st(1, 1, 0, 0), "fault bits");
      check({14'h0, host_alert_line_n, output_on}, 16'h0, "fault off");
      temp(130, (d + 1) * UNIT + 4);
      check({15'h0, output_on}, 16'h0, "hot stays off");
      temp(25, 0);
      wait_out(1'b1, (d + 1) * UNIT + 8);
      t1 = cyc;
      temp(130, 0);
      wait_out(1'b0, 6);
      temp(25, 0);
      wait_out(1'b1, (d + 1) * UNIT + 8);
      check({15'h0, (cyc - t1 >= (d + 1) * UNIT) && (cyc - t1 <= (d + 1) * UNIT + 3)}, 16'h1, "spacing");
      host.clear();
    end
    $display("test retry done");
    host.issue(1'b1, CMD_OT_ACTION, {8'h00, 2'b11, 6'($random(seed))});
    temp(130, 0);
    wait_out(1'b0, 6);
    temp(130, 40);
    check({15'h0, output_on}, 16'h0, "hold while hot");
    temp(25, 0);
    wait_out(1'b1, 5);
    host.clear();
    $display("test hold done");
    for (int k = 0; k < 5; k++) begin
      host.issue(1'b1, CMD_OT_ACTION, {8'h00, LATCH[k]});
      temp(130, 0);
      wait_out(1'b0, 6);
      temp(25, 100);
      check({15'h0, output_on}, 16'h0, "latched off");
      host.clear();
      wait_out(1'b1, 8);
    end
    $display("test latched done");
    host.issue(1'b1, CMD_OT_ACTION, 16'h00b8);
    for (int k = 0; k < 4; k++) begin
      temp(130, 0);
      wait_out(1'b0, 6);
      run(OFFS[k]);
      temp(25, 40);
      check({15'h0, output_on}, 16'h0, "commanded off");
      run(4'b1110);
      wait_out(1'b1, 16);
      host.clear();
    end
    $display("test command off done");
    final_report();
  end
endmodule
